// ---- hw/hmcg_pkg.sv ----
// Package: register map, field layout and reset values of the modem control and GPIO block
package hmcg_pkg;
  localparam int unsigned GP_LINES     = 9;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_DTR_CFG  = 12'h010;
  localparam logic [11:0] OFF_GP_BASE  = 12'h100;
  localparam int unsigned SREG_GP_FIRST = 621;
  localparam int unsigned SREG_GP_LAST  = 628;
  localparam int unsigned SREG_DTR_A    = 552;
  localparam int unsigned SREG_DTR_B    = 553;
  localparam int unsigned SREG_AN0      = 701;
  localparam int unsigned SREG_AN1      = 702;
  localparam logic [11:0] OFF_AN0      = 12'h200;
  localparam logic [11:0] OFF_AN1      = 12'h204;
  // Control bits
  localparam int unsigned CTRL_RING    = 0;
  localparam int unsigned CTRL_LINK    = 1;
  localparam int unsigned CTRL_HSPEED  = 2;
  localparam int unsigned CTRL_TXHOLD  = 3;
  localparam int unsigned CTRL_RXFULL  = 4;
  // Status and interrupt bits
  localparam int unsigned ST_DSR       = 0;
  localparam int unsigned ST_CTS       = 1;
  localparam int unsigned EV_DSR_DROP  = 0;
  localparam int unsigned EV_DSR_RISE  = 1;
  localparam int unsigned EV_CTS_CHG   = 2;
  localparam int unsigned EV_GP_CHG    = 3;
  localparam int unsigned EV_BITS      = 4;
  // Per-line config word: [0] out enable, [1] out value, [3:2] pull, [4] pull strong
  localparam int unsigned GPC_DIR      = 0;
  localparam int unsigned GPC_VAL      = 1;
  localparam int unsigned GPC_PULL_LO  = 2;
  localparam int unsigned GPC_PULL_HI  = 3;
  localparam int unsigned GPC_STRONG   = 4;
  localparam int unsigned GPC_IN       = 8;
  // Pull-down weak, input direction
  localparam logic [4:0]  GPC_RESET    = 5'h04;
  localparam logic [1:0]  DTR_RESET    = 2'h0;
  localparam logic [4:0]  CTRL_RESET   = 5'h00;
  localparam int unsigned GP_DTR_IDX   = 2;
  localparam int unsigned GP_LED_IDX   = 3;
endpackage : hmcg_pkg

// ---- hw/hmcg_top.sv ----
// Modem control lines and general purpose lines with APB register access
// Contract
// - Transmit and receive data lines idle high when no character is sent.
// - All handshake lines are active low on both sides.
// - Ring indication rests high and goes low while a remote peer sets up a connection.
// - Carrier detect is high with no link and low while a link is established.
// - In high-speed mode a data-set-ready deassertion requests drop or online command mode; the code does so only while a link is established.
// - Each general purpose line is set as input or output with weak or strong pull.
// - At reset every general purpose line is an input with a weak pull-down.
// - Lines six, seven and eight stay inputs until software changes them.
// - Software reads and controls the general purpose lines through indexed registers.
// - Line four lights the LED at logic one; as input the host drives it.
// - Line three doubles as active-low data-terminal-ready, chosen by a config register.
// - The two analogue channels are readable through two registers.
module hmcg_top
  import hmcg_pkg::*;
#(
  parameter int unsigned AN_WIDTH = 8
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_data_set_ready_n,
  input  wire logic                  i_clear_to_send_n,
  input  wire logic                  i_tx_data,
  output logic                       o_tx_line,
  output logic                       o_request_to_send_n,
  output logic                       o_ring_indication_n,
  output logic                       o_carrier_detect_n,
  output logic                       o_tx_allowed,
  output logic                       o_drop_request,
  input  wire logic [GP_LINES-1:0]   i_gp_line,
  output logic      [GP_LINES-1:0]   o_gp_line,
  output logic      [GP_LINES-1:0]   o_gp_line_oe_n,
  output logic      [GP_LINES-1:0]   o_gp_pull_up,
  output logic      [GP_LINES-1:0]   o_gp_pull_down,
  output logic      [GP_LINES-1:0]   o_gp_pull_strong,
  input  wire logic [AN_WIDTH-1:0]   i_analog_0,
  input  wire logic [AN_WIDTH-1:0]   i_analog_1,
  output logic                       o_irq
);

  // Channel word must fit the 16-bit read field
  if (AN_WIDTH < 1 || AN_WIDTH > 16) begin : gen_bad_an_width
    $error("AN_WIDTH must be 1 to 16");
  end

  function automatic logic [31:0] hmcg_word(input logic [15:0] v);
    hmcg_word = {16'h0000, v};
  endfunction : hmcg_word

  // Pin synchronisers, two stages
  logic [GP_LINES+3:0] sync_a;
  logic [GP_LINES+3:0] sync_b;
  logic [2*AN_WIDTH-1:0] an_a;
  logic [2*AN_WIDTH-1:0] an_b;
  logic dsr_n;
  logic cts_n;
  logic txd;
  logic [GP_LINES-1:0] gp_in;
  assign dsr_n = sync_b[0];
  assign cts_n = sync_b[1];
  assign txd   = sync_b[2];
  assign gp_in = sync_b[GP_LINES+2:3];

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      // Idle levels: lines pulled low, handshakes and data high, so no false event
      sync_a <= {1'b1, {GP_LINES{1'b0}}, 3'b111};
      sync_b <= {1'b1, {GP_LINES{1'b0}}, 3'b111};
      an_a   <= '0;
      an_b   <= '0;
    end else begin
      sync_a <= {1'b1, i_gp_line, i_tx_data, i_clear_to_send_n, i_data_set_ready_n};
      sync_b <= sync_a;
      an_a   <= {i_analog_1, i_analog_0};
      an_b   <= an_a;
    end
  end

  // Register state
  logic [4:0]          ctrl;
  logic [4:0]          next_ctrl;
  logic [1:0]          dtr_cfg;
  logic [1:0]          next_dtr_cfg;
  logic [4:0]          gp_cfg [GP_LINES];
  logic [4:0]          next_gp_cfg [GP_LINES];
  logic [EV_BITS-1:0]  irq_stat;
  logic [EV_BITS-1:0]  next_irq_stat;
  logic [EV_BITS-1:0]  irq_mask;
  logic [EV_BITS-1:0]  next_irq_mask;
  logic                dsr_prev;
  logic                cts_prev;
  logic [GP_LINES-1:0] gp_prev;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic                acc;
  logic                done;
  logic                wr;
  logic [EV_BITS-1:0]  ev;
  logic [3:0]          gp_idx;
  logic                gp_hit;

  // Read data fetched in the first access cycle; writes land on the
  // completing edge, where the master samples pready high
  assign acc  = i_psel && i_penable && !o_pready;
  assign done = i_psel && i_penable && o_pready;
  assign wr   = done && i_pwrite;
  assign gp_idx = 4'(i_paddr[5:2]);
  assign gp_hit = (i_paddr[11:6] == OFF_GP_BASE[11:6]) && (i_paddr[1:0] == 2'h0)
                  && (gp_idx < 4'(GP_LINES));

  always_comb begin
    ev = '0;
    ev[EV_DSR_DROP] = !dsr_prev && dsr_n;
    ev[EV_DSR_RISE] = dsr_prev && !dsr_n;
    ev[EV_CTS_CHG]  = cts_prev != cts_n;
    ev[EV_GP_CHG]   = gp_prev != gp_in;
  end

  always_comb begin
    next_ctrl     = ctrl;
    next_dtr_cfg  = dtr_cfg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_prdata   = '0;
    next_pready   = acc;
    next_pslverr  = 1'b0;
    for (int i = 0; i < GP_LINES; i++) begin
      next_gp_cfg[i] = gp_cfg[i];
    end
    if (acc || wr) begin
      if (gp_hit) begin
        if (wr) begin
          next_gp_cfg[gp_idx] = i_pwdata[4:0];
        end
        next_prdata = hmcg_word({7'h00, gp_in[gp_idx], 3'h0, gp_cfg[gp_idx]});
      end else begin
        case (i_paddr)
          OFF_CTRL: begin
            if (wr) begin
              next_ctrl = i_pwdata[4:0];
            end
            next_prdata = hmcg_word({11'h000, ctrl});
          end
          OFF_STATUS: begin
            next_prdata = hmcg_word({14'h0000, cts_n, dsr_n});
          end
          OFF_IRQ_STAT: begin
            if (wr) begin
              next_irq_stat = irq_stat & ~i_pwdata[EV_BITS-1:0];
            end
            next_prdata = hmcg_word({12'h000, irq_stat});
          end
          OFF_IRQ_MASK: begin
            if (wr) begin
              next_irq_mask = i_pwdata[EV_BITS-1:0];
            end
            next_prdata = hmcg_word({12'h000, irq_mask});
          end
          OFF_DTR_CFG: begin
            if (wr) begin
              next_dtr_cfg = i_pwdata[1:0];
            end
            next_prdata = hmcg_word({14'h0000, dtr_cfg});
          end
          OFF_AN0: next_prdata = hmcg_word(16'(an_b[AN_WIDTH-1:0]));
          OFF_AN1: next_prdata = hmcg_word(16'(an_b[2*AN_WIDTH-1:AN_WIDTH]));
          default: next_pslverr = 1'b1;
        endcase
      end
    end
    // Completing edge: the answer already stands, only the write acts
    if (!acc) begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
    end
    // Set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl      <= CTRL_RESET;
      dtr_cfg   <= DTR_RESET;
      irq_stat  <= '0;
      irq_mask  <= '0;
      dsr_prev  <= 1'b1;
      cts_prev  <= 1'b1;
      gp_prev   <= '0;
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      for (int i = 0; i < GP_LINES; i++) begin
        gp_cfg[i] <= GPC_RESET;
      end
    end else begin
      ctrl      <= next_ctrl;
      dtr_cfg   <= next_dtr_cfg;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      dsr_prev  <= dsr_n;
      cts_prev  <= cts_n;
      gp_prev   <= gp_in;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
      for (int i = 0; i < GP_LINES; i++) begin
        gp_cfg[i] <= next_gp_cfg[i];
      end
    end
  end

  // Pin drive, all registered
  logic [GP_LINES-1:0] next_gp_out;
  logic [GP_LINES-1:0] next_gp_oe_n;
  logic [GP_LINES-1:0] next_pu;
  logic [GP_LINES-1:0] next_pd;
  logic [GP_LINES-1:0] next_ps;

  always_comb begin
    for (int i = 0; i < GP_LINES; i++) begin
      // LED lit by logic one on the line
      next_gp_out[i]  = gp_cfg[i][GPC_VAL];
      next_gp_oe_n[i] = !gp_cfg[i][GPC_DIR];
      next_pu[i]      = gp_cfg[i][GPC_PULL_HI];
      next_pd[i]      = gp_cfg[i][GPC_PULL_LO];
      next_ps[i]      = gp_cfg[i][GPC_STRONG];
    end
    // Line three as active-low terminal ready
    if (dtr_cfg[0]) begin
      next_gp_oe_n[GP_DTR_IDX] = 1'b0;
      next_gp_out[GP_DTR_IDX]  = !(dtr_cfg[1] || ctrl[CTRL_LINK]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_gp_line           <= '0;
      o_gp_line_oe_n      <= '1;
      o_gp_pull_up        <= '0;
      o_gp_pull_down      <= '1;
      o_gp_pull_strong    <= '0;
      o_tx_line           <= 1'b1;
      o_request_to_send_n <= 1'b1;
      o_ring_indication_n <= 1'b1;
      o_carrier_detect_n  <= 1'b1;
      o_tx_allowed        <= 1'b0;
      o_drop_request      <= 1'b0;
      o_irq               <= 1'b0;
    end else begin
      o_gp_line           <= next_gp_out;
      o_gp_line_oe_n      <= next_gp_oe_n;
      o_gp_pull_up        <= next_pu;
      o_gp_pull_down      <= next_pd;
      o_gp_pull_strong    <= next_ps;
      o_tx_line           <= (!cts_n && !ctrl[CTRL_TXHOLD]) ? txd : 1'b1;
      o_tx_allowed        <= !cts_n && !ctrl[CTRL_TXHOLD];
      o_request_to_send_n <= ctrl[CTRL_RXFULL];
      o_ring_indication_n <= !ctrl[CTRL_RING];
      o_carrier_detect_n  <= !ctrl[CTRL_LINK];
      // Drop or command request in high-speed mode
      o_drop_request      <= ctrl[CTRL_HSPEED] && ctrl[CTRL_LINK] && dsr_n;
      o_irq               <= |(next_irq_stat & next_irq_mask);
    end
  end

  chk_ring_follow: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ##1 o_ring_indication_n == !$past(ctrl[CTRL_RING])) else $error("ring mismatch");
  chk_carrier_link: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(ctrl[CTRL_LINK]) |=> !o_carrier_detect_n) else $error("carrier not low");
  chk_drop_req: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (ctrl[CTRL_HSPEED] && ctrl[CTRL_LINK] && dsr_n) |=> o_drop_request)
    else $error("drop missing");
  chk_tx_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    cts_n |=> o_tx_line) else $error("tx not idle");
  chk_rts_full: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ctrl[CTRL_RXFULL] |=> o_request_to_send_n) else $error("rts low when full");
  chk_gp_reset: assert property (@(posedge i_sys_clk)
    i_sys_rst |=> (&o_gp_line_oe_n && &o_gp_pull_down && !(|o_gp_pull_strong)))
    else $error("gp reset config");
  chk_line_six_in: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (!gp_cfg[5][GPC_DIR] && !$past(gp_cfg[5][GPC_DIR])) |-> o_gp_line_oe_n[5])
    else $error("line six driven");
  chk_dtr_drive: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    dtr_cfg[0] |=> !o_gp_line_oe_n[GP_DTR_IDX]) else $error("dtr not driven");
  chk_gp_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (wr && gp_hit) |=> (gp_cfg[$past(gp_idx)] == $past(i_pwdata[4:0])))
    else $error("gp write lost");
  chk_irq_level: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_irq == |(irq_stat & irq_mask)) else $error("irq level");
  cov_link_up: cover property (@(posedge i_sys_clk) $fell(o_carrier_detect_n));
  cov_drop: cover property (@(posedge i_sys_clk) $rose(o_drop_request));
  cov_irq: cover property (@(posedge i_sys_clk) $rose(o_irq));
endmodule : hmcg_top

// ---- dv/hmcg_host_model.sv ----
// Host side model: handshake drivers and general purpose wire resolution
module hmcg_host_model
  import hmcg_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_host_dtr_n,
  input  wire logic                i_host_rts_n,
  input  wire logic [GP_LINES-1:0] i_host_drive,
  input  wire logic [GP_LINES-1:0] i_host_val,
  input  wire logic [GP_LINES-1:0] i_dev_line,
  input  wire logic [GP_LINES-1:0] i_dev_oe_n,
  input  wire logic [GP_LINES-1:0] i_pull_up,
  input  wire logic [GP_LINES-1:0] i_pull_down,
  output logic                     o_dsr_n,
  output logic                     o_cts_n,
  output logic [GP_LINES-1:0]      o_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  always @(posedge i_clk) flip <= ~flip;
  assign o_dsr_n = i_host_dtr_n;
  assign o_cts_n = i_host_rts_n;
  // Host drives lines left as inputs
  always_comb begin
    for (int i = 0; i < GP_LINES; i++) begin
      if (!i_dev_oe_n[i]) o_wire[i] = i_dev_line[i];
      else if (i_host_drive[i]) o_wire[i] = i_host_val[i];
      else if (i_pull_up[i]) o_wire[i] = 1'b1;
      else if (i_pull_down[i]) o_wire[i] = 1'b0;
      // Floating line: never settle to a stable guess
      else o_wire[i] = flip;
    end
  end
endmodule : hmcg_host_model

// ---- dv/hmcg_top_tb.sv ----
// Self-checking bench for the modem control and general purpose line block
module hmcg_top_tb
  import hmcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, txd = 1'b1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, tx_line, rts_n, ri_n, dcd_n, tx_ok, drop, irq, dsr_n, cts_n;
  logic dtr_h = 1'b0, rts_h = 1'b0;
  logic [8:0] gp_o, oe_n, pu, pd, ps, gp_w, drv = '0, val = '0;
  logic [7:0] an0 = 8'h5A, an1 = 8'hC3;
  int err_count = 0, num_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  hmcg_top dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_data_set_ready_n(dsr_n),
    .i_clear_to_send_n(cts_n), .i_tx_data(txd), .o_tx_line(tx_line),
    .o_request_to_send_n(rts_n), .o_ring_indication_n(ri_n), .o_carrier_detect_n(dcd_n),
    .o_tx_allowed(tx_ok), .o_drop_request(drop), .i_gp_line(gp_w), .o_gp_line(gp_o),
    .o_gp_line_oe_n(oe_n), .o_gp_pull_up(pu), .o_gp_pull_down(pd), .o_gp_pull_strong(ps),
    .i_analog_0(an0), .i_analog_1(an1), .o_irq(irq));
  hmcg_host_model host_u (.i_clk(clk), .i_host_dtr_n(dtr_h), .i_host_rts_n(rts_h),
    .i_host_drive(drv), .i_host_val(val), .i_dev_line(gp_o), .i_dev_oe_n(oe_n),
    .i_pull_up(pu), .i_pull_down(pd), .o_dsr_n(dsr_n), .o_cts_n(cts_n), .o_wire(gp_w));
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Setup, then hold access until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle edge so a following call never rewrites psel in this step
    @(posedge clk);
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic t_reset;
    chk({tx_line, rts_n, ri_n, dcd_n, irq}, 5'h1E);
    chk({oe_n, pd, pu}, {9'h1FF, 9'h1FF, 9'h000});
    for (int i = 5; i < 8; i++) begin
      apb(1'b0, OFF_GP_BASE + 12'(4 * i), '0);
      chk(q[7:0], GPC_RESET);
    end
    apb(1'b0, 12'h0F0, '0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    // Only the DSR and CTS assertions after reset, no line event
    apb(1'b0, OFF_IRQ_STAT, '0);
    chk(q, 32'h6);
  endtask : t_reset
  task automatic t_modem;
    apb(1'b1, OFF_CTRL, 32'h1);
    tick(2);
    chk({ri_n, dcd_n}, 2'h1);
    apb(1'b1, OFF_CTRL, 32'h2);
    tick(2);
    chk({ri_n, dcd_n}, 2'h2);
  endtask : t_modem
  task automatic t_gp;
    apb(1'b1, OFF_GP_BASE + 12'h00C, 32'h3);
    apb(1'b1, OFF_GP_BASE, 32'h18);
    drv <= 9'h010;
    val <= 9'h010;
    tick(8);
    chk({gp_o[3], oe_n[3]}, 2'h2);
    chk({pu[0], ps[0], pd[0], irq}, 4'hC);
    apb(1'b0, OFF_GP_BASE, '0);
    chk(q, 32'h118);
    apb(1'b0, OFF_GP_BASE + 12'h010, '0);
    chk(q, 32'h104);
  endtask : t_gp
  task automatic t_dsr;
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'hF);
    apb(1'b1, OFF_CTRL, 32'h6);
    // DSR deasserted while linked in high-speed mode
    dtr_h <= 1'b1;
    tick(8);
    chk({irq, drop}, 2'h3);
    apb(1'b0, OFF_IRQ_STAT, '0);
    chk(q[EV_DSR_DROP], 1'b1);
    // Host asserts DSR again; its event meets the clear, set wins
    dtr_h <= 1'b0;
    apb(1'b1, OFF_IRQ_STAT, 32'hF);
    tick(6);
    chk({irq, drop}, 2'h0);
    apb(1'b0, OFF_IRQ_STAT, '0);
    chk(q, 32'h2);
  endtask : t_dsr
  task automatic t_cts;
    rts_h <= 1'b1;
    txd <= 1'b0;
    tick(6);
    chk({tx_ok, tx_line}, 2'h1);
    rts_h <= 1'b0;
    tick(6);
    chk({tx_ok, tx_line}, 2'h2);
    apb(1'b1, OFF_CTRL, 32'h10);
    tick(2);
    chk(rts_n, 1'b1);
  endtask : t_cts
  task automatic t_misc;
    // No link yet: DTR driven but deasserted
    apb(1'b1, OFF_DTR_CFG, 32'h1);
    tick(2);
    chk({oe_n[2], gp_o[2]}, 2'h1);
    apb(1'b1, OFF_DTR_CFG, 32'h3);
    tick(2);
    chk({oe_n[2], gp_o[2]}, 2'h0);
    apb(1'b0, OFF_AN0, '0);
    chk(q, 32'h5A);
    apb(1'b0, OFF_AN1, '0);
    chk(q, 32'hC3);
  endtask : t_misc
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_modem();
    t_gp();
    t_dsr();
    t_cts();
    t_misc();
    wrap_up();
  end
endmodule : hmcg_top_tb
